// ===== src/tfds_fifo_mem.sv
`timescale 1ns/10ps
module tfds_fifo_mem #(
    parameter int WIDTH = 38,
    parameter int AW = 4
) (
    input wire logic i_clk_sys, // system clock
    input wire logic i_we, // write strobe
    input wire logic [AW-1:0] i_waddr, // write address
    input wire logic [WIDTH-1:0] i_wdata, // write data
    input wire logic [AW-1:0] i_raddr, // read address
    output logic [WIDTH-1:0] o_rdata // read data, combinational
);
    // no reset on the array: contents only count once a pointer covers them
    logic [WIDTH-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge i_clk_sys)
    begin
        if (i_we)
        begin
            mem[i_waddr] <= i_wdata;
        end
    end

    assign o_rdata = mem[i_raddr];
endmodule // tfds_fifo_mem

// ===== src/tfds_pkg.sv
package tfds_pkg;
    localparam int WORD_W = 38;
    localparam int ADDR_W = 16;
    localparam int DEPTH_LOG2 = 4;
    localparam int CLK_MHZ = 250;
    localparam int HS_RELEASE_NS = 125;
    // longest time, rounded down to whole cycles
    localparam int HS_RELEASE_CYC = (HS_RELEASE_NS * CLK_MHZ) / 1000;
    localparam int HS_CNT_W = 6;
    // read pipeline: stage index (cycle after start) at which the input buffer loads
    localparam int RD_IB_STAGE = 4;
    localparam logic [WORD_W-1:0] WORD_RST = 38'h0;
    localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0;

    typedef enum logic [1:0] {
        HS_IDLE = 2'b00,
        HS_STROBE = 2'b01,
        HS_ASSERT = 2'b10,
        HS_RELEASE = 2'b11
    } tfds_hs_t;
endpackage

// ===== src/tfds_sequencer.sv
`timescale 1ns/10ps
module tfds_sequencer
    import tfds_pkg::*;
#(
    parameter int WORD_WIDTH = tfds_pkg::WORD_W,
    parameter int ADDR_WIDTH = tfds_pkg::ADDR_W,
    parameter int FIFO_AW = tfds_pkg::DEPTH_LOG2
) (
    input wire logic i_clk_sys, // 250 mhz instruction clock
    input wire logic i_nrst, // async reset, active low
    input wire logic i_in_xfer, // input transfer instruction this cycle
    input wire logic i_out_xfer, // output transfer instruction this cycle
    input wire logic i_wait_device_status, // hold for device handshake
    input wire logic i_dma_read_start, // dma read instruction
    input wire logic i_dma_write_start, // dma write instruction
    input wire logic i_fifo_advance, // advance read pointer
    input wire logic i_fifo_clear, // clear both pointers
    input wire logic i_load_fifo_from_bus, // load output buffer from data bus
    input wire logic i_drive_bus_from_fifo, // put output buffer on data bus
    input wire logic [ADDR_WIDTH-1:0] i_alu_out, // alu result, dma address
    input wire logic [WORD_WIDTH-1:0] i_bus_data, // internal data bus
    input wire logic [WORD_WIDTH-1:0] i_dev_in_data, // external device input lines
    input wire logic i_device_status_line_n, // device status, active low
    input wire logic [WORD_WIDTH-1:0] i_host_rd_data, // host memory read data
    output logic [WORD_WIDTH-1:0] o_bus_data, // output buffer word to data bus
    output logic o_data_valid, // output buffer holds a real word
    output logic [WORD_WIDTH-1:0] o_dev_out_data, // external device output bus
    output logic o_in_strobe_n, // input strobe, active low
    output logic o_out_strobe_n, // output strobe, active low
    output logic o_stall, // sequencer hold during handshake
    output logic [ADDR_WIDTH-1:0] o_host_addr, // host memory address register
    output logic o_host_rd_req, // host read cycle request pulse
    output logic o_host_wr_req, // host write cycle request pulse
    output logic [WORD_WIDTH-1:0] o_host_wr_data, // memory write holding register
    output logic o_dma_refused, // dma start dropped, pulse
    output logic o_format_restart // format logic restart pulse
);
    import tfds_pkg::*;

    localparam int PW = FIFO_AW + 1;
    localparam logic [PW-1:0] PTR_ONE = 1;
    localparam logic [PW-1:0] FIFO_FULL = PW'(1 << FIFO_AW);
    localparam logic [HS_CNT_W-1:0] HS_LIMIT = HS_CNT_W'(HS_RELEASE_CYC);
    localparam logic [HS_CNT_W-1:0] HS_CNT_ONE = 1;

    logic [WORD_WIDTH-1:0] input_buffer;
    logic ib_pending;
    logic [WORD_WIDTH-1:0] output_buffer;
    logic ob_valid;
    logic [PW-1:0] rd_ptr;
    logic [PW-1:0] wr_ptr;
    logic [RD_IB_STAGE-1:0] rd_pipe;
    logic wr_stage1;
    logic dma_accepted_last;
    tfds_hs_t hs_state;
    logic hs_is_in;
    logic [HS_CNT_W-1:0] hs_cnt;

    logic [PW-1:0] next_rd_ptr;
    logic [PW-1:0] next_wr_ptr;
    logic [WORD_WIDTH-1:0] next_output_buffer;
    logic next_ob_valid;
    tfds_hs_t next_hs_state;
    logic next_hs_is_in;
    logic [HS_CNT_W-1:0] next_hs_cnt;

    wire [PW-1:0] fifo_count = wr_ptr - rd_ptr;
    wire fifo_empty = (fifo_count == '0);
    wire fifo_full = (fifo_count == FIFO_FULL);
    wire fifo_more = (fifo_count > PTR_ONE);
    // a pending input buffer word is written one cycle after it was loaded, unless the fifo is full and not being cleared
    wire wr_fire = ib_pending & (~fifo_full | i_fifo_clear);
    // the dma write start advances the fifo in the following cycle
    wire advance = i_fifo_advance | wr_stage1 | i_out_xfer;
    // an advance that meets the first write into an empty fifo steps over that word
    wire adv_ok = advance & (~fifo_empty | wr_fire);
    wire dma_start = i_dma_read_start | i_dma_write_start;
    // back-to-back starts would overrun the shared channel, so the second is dropped
    wire dma_accept = dma_start & ~dma_accepted_last;
    wire rd_accept = i_dma_read_start & dma_accept;
    wire wr_accept = i_dma_write_start & ~i_dma_read_start & dma_accept;
    // read word reaches the input buffer at the end of the channel stage
    wire rd_to_ib = rd_pipe[RD_IB_STAGE-1];
    wire [WORD_WIDTH-1:0] mem_next_word;
    wire [FIFO_AW-1:0] rd_next_addr = FIFO_AW'(rd_ptr + PTR_ONE);
    wire xfer_any = i_in_xfer | i_out_xfer;
    wire status_low = ~i_device_status_line_n;
    wire hs_timeout = (hs_cnt >= HS_LIMIT);

    tfds_fifo_mem #(
        .WIDTH(WORD_WIDTH),
        .AW(FIFO_AW)
    ) u_mem (
        .i_clk_sys(i_clk_sys),
        .i_we(wr_fire),
        .i_waddr(i_fifo_clear ? '0 : wr_ptr[FIFO_AW-1:0]),
        .i_wdata(input_buffer),
        .i_raddr(rd_next_addr),
        .o_rdata(mem_next_word)
    );

    // pointer update; a write that lands during a clear survives it
    always_comb
    begin
        next_rd_ptr = rd_ptr;
        next_wr_ptr = wr_ptr;
        if (i_fifo_clear)
        begin
            next_rd_ptr = '0;
            next_wr_ptr = wr_fire ? PTR_ONE : '0;
        end
        else
        begin
            if (adv_ok)
            begin
                next_rd_ptr = rd_ptr + PTR_ONE;
            end
            if (wr_fire)
            begin
                next_wr_ptr = wr_ptr + PTR_ONE;
            end
        end
    end

    // output buffer: the word at the read pointer, or the bypassed input word when empty
    always_comb
    begin
        next_output_buffer = output_buffer;
        next_ob_valid = ob_valid;
        if (i_fifo_clear)
        begin
            if (wr_fire)
            begin
                next_output_buffer = input_buffer;
                next_ob_valid = 1'b1;
            end
            else
            begin
                next_ob_valid = 1'b0;
            end
        end
        else if (i_load_fifo_from_bus)
        begin
            // a bus load marks the word valid but never moves a pointer
            next_output_buffer = i_bus_data;
            next_ob_valid = 1'b1;
        end
        else if (adv_ok)
        begin
            if (fifo_more)
            begin
                next_output_buffer = mem_next_word;
                next_ob_valid = 1'b1;
            end
            else if (wr_fire & ~fifo_empty)
            begin
                next_output_buffer = input_buffer;
                next_ob_valid = 1'b1;
            end
            else
            begin
                next_ob_valid = 1'b0;
            end
        end
        else if (fifo_empty & wr_fire)
        begin
            // first word into an empty fifo shows up at the start of the next cycle
            next_output_buffer = input_buffer;
            next_ob_valid = 1'b1;
        end
        else if (advance & fifo_empty)
        begin
            next_ob_valid = 1'b0;
        end
    end

    // device handshake: strobe low, wait for status low, then wait for its release
    always_comb
    begin
        next_hs_state = hs_state;
        next_hs_is_in = hs_is_in;
        next_hs_cnt = hs_cnt;
        case (hs_state)
            HS_IDLE, HS_STROBE:
            begin
                next_hs_state = HS_IDLE;
                if (xfer_any)
                begin
                    next_hs_is_in = i_in_xfer;
                    next_hs_state = i_wait_device_status ? HS_ASSERT : HS_STROBE;
                end
            end
            HS_ASSERT:
            begin
                // no timeout: the sequence holds until the device answers
                if (status_low)
                begin
                    next_hs_state = HS_RELEASE;
                    next_hs_cnt = '0;
                end
            end
            HS_RELEASE:
            begin
                next_hs_cnt = hs_cnt + HS_CNT_ONE;
                // a status line still low after the window is ignored
                if (~status_low | hs_timeout)
                begin
                    next_hs_state = HS_IDLE;
                end
            end
            default:
            begin
                next_hs_state = HS_IDLE;
            end
        endcase
    end

    wire strobe_next = (next_hs_state == HS_STROBE) | (next_hs_state == HS_ASSERT);
    wire stall_next = (next_hs_state == HS_ASSERT) | (next_hs_state == HS_RELEASE);

    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            rd_ptr <= '0;
            wr_ptr <= '0;
            output_buffer <= WORD_RST;
            ob_valid <= 1'b0;
        end
        else
        begin
            rd_ptr <= next_rd_ptr;
            wr_ptr <= next_wr_ptr;
            output_buffer <= next_output_buffer;
            ob_valid <= next_ob_valid;
        end
    end

    // input buffer: device lines on an input transfer, host word at the channel stage
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            input_buffer <= WORD_RST;
            ib_pending <= 1'b0;
        end
        else
        begin
            if (rd_to_ib)
            begin
                input_buffer <= i_host_rd_data;
            end
            else if (i_in_xfer)
            begin
                input_buffer <= i_dev_in_data;
            end
            ib_pending <= rd_to_ib | i_in_xfer;
        end
    end

    // dma sequencing; the read pipe is not touched by a fifo clear
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            rd_pipe <= '0;
            wr_stage1 <= 1'b0;
            dma_accepted_last <= 1'b0;
            o_host_addr <= ADDR_RST;
            o_host_rd_req <= 1'b0;
            o_host_wr_req <= 1'b0;
            o_dma_refused <= 1'b0;
        end
        else
        begin
            rd_pipe <= {rd_pipe[RD_IB_STAGE-2:0], rd_accept};
            wr_stage1 <= wr_accept;
            dma_accepted_last <= dma_accept;
            if (dma_accept)
            begin
                o_host_addr <= i_alu_out;
            end
            o_host_rd_req <= rd_accept;
            o_host_wr_req <= wr_stage1;
            o_dma_refused <= dma_start & ~dma_accept;
        end
    end

    // capture at the end of the cycle after the write start; later bus loads miss it
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_host_wr_data <= WORD_RST;
        end
        else if (wr_stage1)
        begin
            o_host_wr_data <= output_buffer;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            hs_state <= HS_IDLE;
            hs_is_in <= 1'b0;
            hs_cnt <= '0;
            o_in_strobe_n <= 1'b1;
            o_out_strobe_n <= 1'b1;
            o_stall <= 1'b0;
        end
        else
        begin
            hs_state <= next_hs_state;
            hs_is_in <= next_hs_is_in;
            hs_cnt <= next_hs_cnt;
            o_in_strobe_n <= ~(strobe_next & next_hs_is_in);
            o_out_strobe_n <= ~(strobe_next & ~next_hs_is_in);
            o_stall <= stall_next;
        end
    end

    // device output data only changes on an output transfer, so it is steady under strobe
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_dev_out_data <= WORD_RST;
            o_bus_data <= WORD_RST;
            o_data_valid <= 1'b0;
            o_format_restart <= 1'b0;
        end
        else
        begin
            if (i_out_xfer)
            begin
                o_dev_out_data <= output_buffer;
            end
            if (i_drive_bus_from_fifo)
            begin
                o_bus_data <= output_buffer;
            end
            o_data_valid <= next_ob_valid;
            o_format_restart <= i_fifo_clear;
        end
    end
endmodule // tfds_sequencer

// ===== tb/tfds_far_model.sv
`timescale 1ns/10ps
module tfds_far_model
    import tfds_pkg::*;
(
    input wire logic i_clk_sys, // clock
    input wire logic i_nrst, // reset
    input wire logic i_slow, // late status
    input wire logic i_in_strobe_n, // input strobe
    input wire logic i_out_strobe_n, // output strobe
    input wire logic i_host_rd_req, // read request
    input wire logic [tfds_pkg::ADDR_W-1:0] i_host_addr, // read address
    output logic o_device_status_line_n, // status, active low
    output logic [tfds_pkg::WORD_W-1:0] o_host_rd_data // read word
);
    logic [1:0] pipe;
    logic [ADDR_W-1:0] a1;
    logic [ADDR_W-1:0] a2;
    logic [2:0] cnt;
    wire strobe = !i_in_strobe_n || !i_out_strobe_n;
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            {pipe, a1, a2, cnt} <= '0;
            o_device_status_line_n <= 1'b1;
            o_host_rd_data <= 38'h0;
        end
        else
        begin
            pipe <= {pipe[0], i_host_rd_req};
            a1 <= i_host_rd_req ? i_host_addr : a1;
            a2 <= a1;
            // word valid for one cycle only, toggling otherwise so stale data shows
            o_host_rd_data <= pipe[1] ? {a2, ~a2, 6'h15} : ~o_host_rd_data;
            cnt <= strobe ? cnt + 3'h1 : 3'h0;
            // slow mode answers late, still inside the handshake window
            o_device_status_line_n <= !(strobe && cnt >= (i_slow ? 3'h3 : 3'h0));
        end
    end
endmodule // tfds_far_model

// ===== tb/tfds_seq_props.sv
`timescale 1ns/10ps
module tfds_seq_props #(
    parameter int WORD_WIDTH = 38,
    parameter int ADDR_WIDTH = 16
) (
    input wire logic i_clk_sys, // clock
    input wire logic i_nrst, // reset
    input wire logic i_in_xfer, // input op
    input wire logic i_out_xfer, // output op
    input wire logic i_dma_read_start, // read start
    input wire logic i_dma_write_start, // write start
    input wire logic i_fifo_clear, // clear
    input wire logic [ADDR_WIDTH-1:0] i_alu_out, // address source
    input wire logic [WORD_WIDTH-1:0] o_dev_out_data, // device bus
    input wire logic o_in_strobe_n, // input strobe
    input wire logic o_out_strobe_n, // output strobe
    input wire logic o_stall, // hold
    input wire logic [ADDR_WIDTH-1:0] o_host_addr, // address reg
    input wire logic o_host_rd_req, // read request
    input wire logic o_host_wr_req, // write request
    input wire logic o_dma_refused, // refusal
    input wire logic o_format_restart // restart
);
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_nrst);
    wire dma_any = i_dma_read_start | i_dma_write_start;
    rd_addr_a: assert property (o_host_rd_req |-> o_host_addr == $past(i_alu_out))
        else $error("read address differs from alu value");
    rd_req_a: assert property (i_dma_read_start |=> o_host_rd_req != o_dma_refused)
        else $error("read start neither requested nor refused");
    wr_req_a: assert property (i_dma_write_start && !i_dma_read_start
        |=> o_dma_refused or (1'b1 ##1 o_host_wr_req)) else $error("write request missing");
    dma_gap_a: assert property ($past(dma_any) && !o_dma_refused && dma_any
        |=> o_dma_refused) else $error("start accepted right after another");
    in_strobe_a: assert property (i_in_xfer && !o_stall |=> !o_in_strobe_n)
        else $error("input strobe missing");
    out_hold_a: assert property (!o_out_strobe_n && !$past(o_out_strobe_n)
        && !$past(i_out_xfer) |-> $stable(o_dev_out_data)) else $error("out data moved");
    stall_end_a: assert property (($rose(o_in_strobe_n) || $rose(o_out_strobe_n))
        && o_stall |-> ##[0:33] !o_stall) else $error("stall not released");
    restart_a: assert property (i_fifo_clear |=> o_format_restart)
        else $error("format restart missing after clear");
endmodule // tfds_seq_props

bind tfds_sequencer tfds_seq_props #(.WORD_WIDTH(WORD_WIDTH), .ADDR_WIDTH(ADDR_WIDTH))
    tfds_seq_props_inst (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_in_xfer(i_in_xfer),
    .i_out_xfer(i_out_xfer), .i_dma_read_start(i_dma_read_start),
    .i_dma_write_start(i_dma_write_start), .i_fifo_clear(i_fifo_clear), .i_alu_out(i_alu_out),
    .o_dev_out_data(o_dev_out_data), .o_in_strobe_n(o_in_strobe_n),
    .o_out_strobe_n(o_out_strobe_n), .o_stall(o_stall), .o_host_addr(o_host_addr),
    .o_host_rd_req(o_host_rd_req), .o_host_wr_req(o_host_wr_req),
    .o_dma_refused(o_dma_refused), .o_format_restart(o_format_restart));

// ===== tb/tfds_sequencer_bench.sv
`timescale 1ns/10ps
module tfds_sequencer_bench;
    import tfds_pkg::*;
    localparam logic [8:0] IN = 9'h1, OUT = 9'h2, WT = 9'h4, RD = 9'h8, WR = 9'h10;
    localparam logic [8:0] ADV = 9'h20, CLR = 9'h40, LD = 9'h80, DRV = 9'h100;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic slow = 1'b0;
    logic [8:0] ins = 9'h0;
    logic [ADDR_W-1:0] alu = 16'h0;
    logic [WORD_W-1:0] bus = 38'h0;
    logic [WORD_W-1:0] dev = 38'h0;
    logic [WORD_W-1:0] hrd, bus_q, dout, wdat;
    logic [ADDR_W-1:0] haddr;
    logic st_n, valid, in_n, out_n, stall, rreq, wreq, refd;
    int n_fail = 0;
    int samples_checked = 0;
    int nref = 0;
    int nwr = 0;
    tfds_sequencer tfds_sequencer_inst (
        .i_clk_sys(clk), .i_nrst(nrst), .i_in_xfer(ins[0]), .i_out_xfer(ins[1]),
        .i_wait_device_status(ins[2]), .i_dma_read_start(ins[3]), .i_dma_write_start(ins[4]),
        .i_fifo_advance(ins[5]), .i_fifo_clear(ins[6]), .i_load_fifo_from_bus(ins[7]),
        .i_drive_bus_from_fifo(ins[8]), .i_alu_out(alu), .i_bus_data(bus), .i_dev_in_data(dev),
        .i_device_status_line_n(st_n), .i_host_rd_data(hrd), .o_bus_data(bus_q),
        .o_data_valid(valid), .o_dev_out_data(dout), .o_in_strobe_n(in_n),
        .o_out_strobe_n(out_n), .o_stall(stall), .o_host_addr(haddr), .o_host_rd_req(rreq),
        .o_host_wr_req(wreq), .o_host_wr_data(wdat), .o_dma_refused(refd),
        .o_format_restart());
    tfds_far_model tfds_far_model_inst (
        .i_clk_sys(clk), .i_nrst(nrst), .i_slow(slow), .i_in_strobe_n(in_n),
        .i_out_strobe_n(out_n), .i_host_rd_req(rreq), .i_host_addr(haddr),
        .o_device_status_line_n(st_n), .o_host_rd_data(hrd));
    initial forever #2 clk = ~clk;
    always @(posedge clk)
    begin
        nref <= nref + int'(refd === 1'b1);
        nwr <= nwr + int'(wreq === 1'b1);
    end
    task automatic check(input string what, input logic [WORD_W-1:0] seen, exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task cyc(input logic [8:0] v);
        ins <= v;
        @(posedge clk);
    endtask
    // sequencer must hold while stalled, so no instruction is given meanwhile
    task automatic wait_stall();
        int n;
        n = 0;
        ins <= 9'h0;
        @(negedge clk);
        check("stall", {37'h0, stall}, 38'h1);
        while (stall !== 1'b0 && n < 80)
        begin
            @(negedge clk);
            n++;
        end
        check("stall end", 38'(n < 80), 38'h1);
        @(posedge clk);
    endtask
    task t_in_empty();
        cyc(CLR);
        dev <= 38'h0a5;
        cyc(IN);
        cyc(0);
        cyc(DRV);
        cyc(0);
        check("bus", bus_q, 38'h0a5);
        check("valid", {37'h0, valid}, 38'h1);
        $display("in to empty done");
    endtask
    task t_fifo_order();
        cyc(IN);
        cyc(IN);
        cyc(0);
        cyc(CLR);
        dev <= 38'h4;
        cyc(IN);
        dev <= 38'h5;
        cyc(IN);
        cyc(0);
        cyc(DRV);
        cyc(ADV | DRV);
        check("first word", bus_q, 38'h4);
        cyc(DRV);
        cyc(0);
        check("second word", bus_q, 38'h5);
        $display("fifo order done");
    endtask
    task automatic t_dma_read();
        int r0;
        r0 = nref;
        cyc(CLR);
        alu <= 16'h1234;
        cyc(RD);
        alu <= 16'h0bad;
        // a write start here keeps reads apart yet still hits the one-cycle refusal
        cyc(WR);
        alu <= 16'h0;
        cyc(0);
        cyc(CLR);
        cyc(0);
        cyc(0);
        cyc(DRV);
        cyc(0);
        check("read word", bus_q, {16'h1234, 16'hedcb, 6'h15});
        check("address", 38'(haddr), 38'h1234);
        check("refusals", 38'(nref - r0), 38'h1);
        $display("dma read done");
    endtask
    task automatic t_dma_write();
        int w0;
        w0 = nwr;
        bus <= 38'h1;
        cyc(LD | WR);
        bus <= 38'h2;
        cyc(LD);
        cyc(0);
        check("late load", wdat, 38'h1);
        cyc(CLR);
        dev <= 38'hd1;
        cyc(IN);
        dev <= 38'hd2;
        cyc(IN);
        cyc(0);
        cyc(WR | ADV);
        cyc(0);
        cyc(0);
        check("advanced word", wdat, 38'hd2);
        check("drained", {37'h0, valid}, 38'h0);
        // the second request pulse is only counted at the next edge
        cyc(0);
        check("write reqs", 38'(nwr - w0), 38'h2);
        cyc(CLR);
        dev <= 38'hd3;
        cyc(IN);
        dev <= 38'hd4;
        cyc(IN | ADV);
        cyc(WR);
        cyc(0);
        cyc(0);
        check("advance before", wdat, 38'hd4);
        $display("dma write done");
    endtask
    task t_handshake();
        for (int s = 0; s < 2; s++)
        begin
            slow <= s[0];
            cyc(CLR);
            dev <= 38'h3c + 38'(s);
            cyc(IN | WT);
            wait_stall();
            cyc(DRV);
            cyc(0);
            check("in word", bus_q, 38'h3c + 38'(s));
            bus <= 38'h77 + 38'(s);
            cyc(LD);
            cyc(OUT | WT);
            wait_stall();
            check("out word", dout, 38'h77 + 38'(s));
        end
        $display("handshake done");
    endtask
    task report_and_stop();
        $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        t_in_empty();
        t_fifo_order();
        t_dma_read();
        t_dma_write();
        t_handshake();
        report_and_stop();
    end
    initial
    begin
        // the tests need about a hundred cycles; this is a wide margin
        #40000;
        n_fail++;
        report_and_stop();
    end
endmodule // tfds_sequencer_bench
